// [fspc_ctrl.sv]
// Flash self-program controller: registers, page buffer and op sequencer.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module fspc_ctrl import fspc_pkg::*; #(
  parameter int ERASE0 = ERASE0_CYC,
  parameter int WRITE0 = WRITE0_CYC,
  parameter int ERASE1 = ERASE1_CYC,
  parameter int WRITE1 = WRITE1_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] flash_rdata,
  output fspc_flash_t flash_cmd,
  output logic cpu_halt,
  output logic chip_reset
);

  // Sequencer states; idle is the only state that takes new triggers.
  typedef enum logic [2:0] {
    S_IDLE, S_UNLOCK, S_CLEAR, S_ERASE, S_WRITE, S_READ
  } fspc_state_t;

  fspc_state_t state; // Current sequencer state.
  fspc_state_t next_state; // State for the next edge.
  logic [19:0] cnt; // Down counter of the running operation.
  logic [4:0] idx; // Word index for clear and write streaming.
  logic wdone; // Whole page already streamed in the running write.
  logic unlock_status; // Erase/write unlocked flag.
  logic [2:0] op_mode_field; // Selected operation mode.
  logic read_enable_bit; // Read permission.
  logic op_time_select; // Long or short erase/write times.
  logic [7:0] reset_pattern; // Chip reset pattern register.
  logic [13:0] flash_word_address; // Word address pair.
  logic [7:0] dreg [8]; // Data pairs zero to three, low then high.
  logic [15:0] wbuf [PAGE_WORDS]; // Page write buffer.
  logic [31:0] tag; // Words written since the last clear.
  logic idle; // Sequencer takes new requests.
  logic wr_ctl; // Write to the operation control register.
  logic wr_buf; // Accepted write into the page buffer.
  logic key_ok; // Unlock pattern present in pairs one to three.
  logic cnt_done; // Running operation ends this cycle.
  logic [2:0] new_mode; // Mode carried by a control write.
  logic [19:0] dur; // Duration loaded when an operation starts.

  // Register index of a data byte, zero for pair zero low.
  function automatic logic [2:0] dsel(input logic [3:0] a);
    dsel = 3'(a - REG_D0L);
  endfunction

  assign idle = (state == S_IDLE);
  assign wr_ctl = reg_wr && (reg_addr == REG_OPCTL);
  assign new_mode = reg_wdata[B_MODE_LSB +: 3];
  assign cnt_done = (cnt == 20'h00000);
  assign key_ok = ({dreg[7], dreg[5], dreg[3], dreg[6], dreg[4], dreg[2]}
                   == UNLOCK_KEY);
  // Page data is taken only when unlocked and idle.
  assign wr_buf = reg_wr && (reg_addr == REG_D0L + 4'h1) && unlock_status
                  && idle;

  // Duration chosen from the time select bit and the mode.
  always_comb begin
    if (new_mode == MODE_ERASE) begin
      dur = op_time_select ? 20'(ERASE1 - 1) : 20'(ERASE0 - 1);
    end else begin
      dur = op_time_select ? 20'(WRITE1 - 1) : 20'(WRITE0 - 1);
    end
  end

  // Next state; unlock wins over write, write over read.
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (wr_ctl && reg_wdata[B_UNLOCK_TRIG]) begin
          next_state = S_UNLOCK;
        end else if (wr_ctl && reg_wdata[B_WRITE_TRIG] && unlock_status
                     && new_mode == MODE_WRITE) begin
          next_state = S_WRITE;
        end else if (wr_ctl && reg_wdata[B_WRITE_TRIG] && unlock_status
                     && new_mode == MODE_ERASE) begin
          next_state = S_ERASE;
        end else if (wr_ctl && reg_wdata[B_READ_TRIG]
                     && reg_wdata[B_READ_EN] && new_mode == MODE_READ) begin
          next_state = S_READ;
        end else if (reg_wr && reg_addr == REG_TIMBUF
                     && reg_wdata[B_BUF_CLR]) begin
          next_state = S_CLEAR;
        end
      end
      S_CLEAR: begin
        // Clear walks all words, one per cycle.
        if (idx == PAGE_LAST) begin
          next_state = S_IDLE;
        end
      end
      S_UNLOCK, S_ERASE, S_WRITE, S_READ: begin
        if (cnt_done) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Operation counter, loaded when an operation leaves idle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 20'h00000;
    end else if (idle) begin
      case (next_state)
        S_UNLOCK: cnt <= 20'(UNLOCK_CYC - 1);
        S_READ: cnt <= 20'(READ_CYC - 1);
        S_WRITE, S_ERASE: cnt <= dur;
        default: cnt <= 20'h00000;
      endcase
    end else if (!cnt_done) begin
      cnt <= cnt - 20'h00001;
    end
  end

  // Word index: steps through the page in clear and write.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      idx <= 5'h00;
    end else if (state == S_CLEAR || (state == S_WRITE && idx != PAGE_LAST)) begin
      idx <= idx + 5'h01;
    end else if (idle) begin
      idx <= 5'h00;
    end
  end

  // Stream-done flag: the page goes out once, however long the write lasts.
  // Without it the last word would be offered again on every cycle of the write.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wdone <= 1'b0;
    end else if (idle) begin
      wdone <= 1'b0;
    end else if (state == S_WRITE && idx == PAGE_LAST) begin
      wdone <= 1'b1;
    end
  end

  // Unlock status: hardware sets, software may only clear.
  // The hardware set wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      unlock_status <= 1'b0;
    end else if (state == S_UNLOCK && cnt_done && key_ok
                 && op_mode_field == MODE_UNLOCK) begin
      unlock_status <= 1'b1;
    end else if (wr_ctl && !reg_wdata[B_UNLOCK_STATUS]) begin
      unlock_status <= 1'b0;
    end
  end

  // Mode and read enable change only while idle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      op_mode_field <= MODE_WRITE;
      read_enable_bit <= 1'b0;
    end else if (wr_ctl && idle) begin
      op_mode_field <= new_mode;
      read_enable_bit <= reg_wdata[B_READ_EN];
    end
  end

  // Timing select; held while an operation is running.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      op_time_select <= 1'b0;
    end else if (reg_wr && reg_addr == REG_TIMBUF && idle) begin
      op_time_select <= reg_wdata[B_TIME_SEL];
    end
  end

  // Chip reset pattern; a one-cycle reset request on the key.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_pattern <= 8'h00;
      chip_reset <= 1'b0;
    end else begin
      chip_reset <= reg_wr && reg_addr == REG_CHIPRST
                    && reg_wdata == CHIP_RST_KEY;
      if (reg_wr && reg_addr == REG_CHIPRST) begin
        reset_pattern <= reg_wdata;
      end
    end
  end

  // Address pair; page writes step it but stop on the last word.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flash_word_address <= 14'h0000;
    end else if (wr_buf) begin
      if (flash_word_address[4:0] != PAGE_LAST) begin
        flash_word_address <= flash_word_address + 14'h0001;
      end
    end else if (reg_wr && idle && reg_addr == REG_ADDRL) begin
      flash_word_address[7:0] <= reg_wdata;
    end else if (reg_wr && idle && reg_addr == REG_ADDRH) begin
      flash_word_address[13:8] <= reg_wdata[5:0];
    end
  end

  // Data bytes; a finished read lands in pair zero.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        dreg[i] <= 8'h00;
      end
    end else if (state == S_READ && cnt_done) begin
      dreg[0] <= flash_rdata[7:0];
      dreg[1] <= flash_rdata[15:8];
    end else if (reg_wr && reg_addr >= REG_D0L && reg_addr <= REG_D3H) begin
      // Pattern bytes must still land during the unlock window.
      if (idle || state == S_UNLOCK) begin
        dreg[dsel(reg_addr)] <= reg_wdata;
      end
    end
  end

  // Page buffer with its word tags.
  // The clear command goes word by word; a finished write clears every word at once.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tag <= 32'h00000000;
    end else if (state == S_CLEAR) begin
      tag[idx] <= 1'b0;
    end else if ((state == S_WRITE || state == S_ERASE) && cnt_done) begin
      tag <= 32'h00000000;
    end else if (wr_buf) begin
      tag[flash_word_address[4:0]] <= 1'b1;
    end
  end

  // Buffer words, cleared together when a write ends.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        wbuf[i] <= 16'h0000;
      end
    end else if (state == S_WRITE && cnt_done) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        wbuf[i] <= 16'h0000;
      end
    end else if (state == S_CLEAR) begin
      wbuf[idx] <= 16'h0000;
    end else if (wr_buf) begin
      wbuf[flash_word_address[4:0]] <= {reg_wdata, dreg[0]};
    end
  end

  // Flash command: levels per operation and a streamed page.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.erase <= (next_state == S_ERASE);
      flash_cmd.write <= (next_state == S_WRITE);
      flash_cmd.read <= (next_state == S_READ);
      flash_cmd.addr <= flash_word_address;
      flash_cmd.tag <= tag;
      flash_cmd.wvalid <= (state == S_WRITE && !wdone && !cnt_done);
      flash_cmd.widx <= idx;
      flash_cmd.wdata <= wbuf[idx];
    end
  end

  // Core halt covers every started array operation.
  assign cpu_halt = (state == S_ERASE || state == S_WRITE
                     || state == S_READ);

  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_OPCTL: reg_rdata <= {unlock_status, op_mode_field,
          state == S_UNLOCK, state == S_WRITE || state == S_ERASE,
          read_enable_bit, state == S_READ};
        REG_CHIPRST: reg_rdata <= reset_pattern;
        REG_TIMBUF: reg_rdata <= {6'h00, op_time_select,
          state == S_CLEAR};
        REG_ADDRL: reg_rdata <= flash_word_address[7:0];
        REG_ADDRH: reg_rdata <= {2'h0, flash_word_address[13:8]};
        default: begin
          if (reg_addr <= REG_D3H) begin
            reg_rdata <= dreg[dsel(reg_addr)];
          end else begin
            reg_rdata <= 8'h00;
          end
        end
      endcase
    end
  end

  // Assertions on the sequencer and register behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_hi_write;
    wr_buf && flash_word_address[4:0] != PAGE_LAST;
  endsequence

  a_addr_step: assert property (s_hi_write |=>
    flash_word_address == $past(flash_word_address) + 14'h0001)
    else $error("address did not step");

  a_addr_hold: assert property (wr_buf && flash_word_address[4:0] == PAGE_LAST
    |=> $stable(flash_word_address))
    else $error("address left the page");

  a_buf_lock: assert property (!unlock_status |=> $stable(tag) || !idle
    || $past(state) != S_IDLE)
    else $error("buffer took data while locked");

  a_word_load: assert property (wr_buf |=>
    wbuf[$past(flash_word_address[4:0])] == {$past(reg_wdata), $past(dreg[0])})
    else $error("word not loaded");

  a_unlock_only: assert property ($rose(unlock_status) |->
    $past(state) == S_UNLOCK && $past(key_ok))
    else $error("unlock set without pattern");

  // The clear holds for all 32 words: 8 counted here, idle again 25 cycles later.
  a_clear_len: assert property (state == S_IDLE ##1 state == S_CLEAR |->
    (state == S_CLEAR) [*8] ##25 state == S_IDLE)
    else $error("clear length wrong");

  a_write_clr: assert property (state == S_WRITE && cnt_done |=>
    tag == 32'h00000000 && idle)
    else $error("buffer not cleared after write");

  a_read_gate: assert property (idle && $past(idle) ##1 state == S_READ |->
    $past(read_enable_bit) || $past(reg_wdata[B_READ_EN]))
    else $error("read without enable");

  // An accepted erase or write trigger stalls the core from the next cycle on.
  a_halt_busy: assert property (wr_ctl && idle && unlock_status
    && reg_wdata[B_WRITE_TRIG] && !reg_wdata[B_UNLOCK_TRIG]
    && (new_mode == MODE_WRITE || new_mode == MODE_ERASE) |=> cpu_halt)
    else $error("core not halted");

  a_chip_rst: assert property (reg_wr && reg_addr == REG_CHIPRST
    && reg_wdata == CHIP_RST_KEY |=> chip_reset ##1 !chip_reset)
    else $error("chip reset pulse wrong");

  a_busy_addr: assert property (!idle && !$past(idle) |-> $stable(flash_word_address))
    else $error("address moved while busy");

endmodule // fspc_ctrl

// [fspc_pkg.sv]
// Constants and types for the flash self-program controller.
package fspc_pkg;
  // Register indexes on the byte register port.
  localparam logic [3:0] REG_OPCTL = 4'h0;
  localparam logic [3:0] REG_CHIPRST = 4'h1;
  localparam logic [3:0] REG_TIMBUF = 4'h2;
  localparam logic [3:0] REG_ADDRL = 4'h3;
  localparam logic [3:0] REG_ADDRH = 4'h4;
  localparam logic [3:0] REG_D0L = 4'h5;
  localparam logic [3:0] REG_D3H = 4'hC;
  // Bit positions in the control registers.
  localparam int B_UNLOCK_STATUS = 7;
  localparam int B_MODE_LSB = 4;
  localparam int B_UNLOCK_TRIG = 3;
  localparam int B_WRITE_TRIG = 2;
  localparam int B_READ_EN = 1;
  localparam int B_READ_TRIG = 0;
  localparam int B_TIME_SEL = 1;
  localparam int B_BUF_CLR = 0;
  // Operation mode codes.
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // Unlock pattern for data pairs one to three, low then high bytes.
  localparam logic [47:0] UNLOCK_KEY = 48'h40_09_04_C3_0D_00;
  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam int PAGE_WORDS = 32;
  // Timing, each in its own unit, and cycle counts at the clock rate.
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real ERASE0_MS = 3.2;
  localparam real WRITE0_MS = 2.2;
  localparam real ERASE1_MS = 3.7;
  localparam real WRITE1_MS = 3.0;
  localparam real UNLOCK_US = 8.0;
  localparam real READ_NS = 40.0;
  localparam int ERASE0_CYC = int'($ceil(ERASE0_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int WRITE0_CYC = int'($ceil(WRITE0_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int ERASE1_CYC = int'($ceil(ERASE1_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int WRITE1_CYC = int'($ceil(WRITE1_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int UNLOCK_CYC = int'($floor(UNLOCK_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int READ_CYC = int'($ceil(READ_NS / CLK_PERIOD_NS));
  // Command bundle toward the flash array macro.
  typedef struct packed {
    logic erase;
    logic write;
    logic read;
    logic [13:0] addr;
    logic [31:0] tag;
    logic wvalid;
    logic [4:0] widx;
    logic [15:0] wdata;
  } fspc_flash_t;
endpackage

// [fspc_ctrl_tb.sv]
// Self-checking bench for the flash self-program controller, driven through its register port.
`timescale 1ns/10ps
module fspc_ctrl_tb;
  import fspc_pkg::*;
  // Short operation lengths keep the run brief; expectations follow these values.
  // A write must outlast the 32 streamed words, so both write lengths stay above 33.
  localparam int W0 = 40;
  localparam int W1 = 35;
  localparam int E1 = 50;
  logic clock; // System clock.
  logic rst_b; // Active-low reset.
  logic [3:0] reg_addr; // Register index.
  logic [7:0] reg_wdata; // Write data.
  logic reg_wr; // Write strobe.
  logic reg_rd; // Read strobe.
  logic [7:0] reg_rdata; // Read data.
  logic [15:0] flash_rdata; // Word offered by the array.
  fspc_flash_t flash_cmd; // Commands toward the array.
  logic cpu_halt; // Core stall.
  logic chip_reset; // Chip reset pulse.
  int miscompares; // Count of failed comparisons.
  int n_checks; // Count of comparisons made.
  int cyc; // Cycle count for the hang guard.
  int run; // Cycles of the stall seen so far.
  int halt_len; // Length of the last finished stall.
  int wv_n; // Streamed buffer words seen.
  logic [15:0] w1e; // Word streamed for in-page index 1E.
  logic [15:0] w1f; // Word streamed for in-page index 1F.
  logic [7:0] rdv; // Last value read.
  int i; // Loop index.

  fspc_ctrl #(.ERASE0(40), .WRITE0(W0), .ERASE1(E1), .WRITE1(W1)) fspc_ctrl_i (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_rdata(flash_rdata),
    .flash_cmd(flash_cmd), .cpu_halt(cpu_halt), .chip_reset(chip_reset));

  // Clock at 4 ns period.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Measures each stall and records streamed words, so busy lengths are judged to within one cycle.
  always @(posedge clock) begin
    cyc++;
    if (cpu_halt === 1'b1) begin
      run++;
    end else if (run != 0) begin
      halt_len = run;
      run = 0;
    end
    if (flash_cmd.wvalid === 1'b1) begin
      wv_n++;
      if (flash_cmd.widx == 5'h1E) w1e = flash_cmd.wdata;
      if (flash_cmd.widx == 5'h1F) w1f = flash_cmd.wdata;
    end
    // A hang is cut short well beyond the expected length of the run.
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle register write; an idle cycle precedes it so strobes never collide.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle register read; data are taken in the following cycle only.
  // Polling uses it bare, since a status that is about to change has no fixed expectation.
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask

  // Register read followed by a comparison against the expected value.
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    rd(a);
    chk(nm, {8'h00, exp}, {8'h00, rdv});
  endtask

  // Waits for the stall to end, bounded so a stuck busy flag cannot hang the run.
  task automatic wait_idle();
    for (int n = 0; n < 200 && cpu_halt !== 1'b0; n++) @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Main sequence of tests.
  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    flash_rdata = 16'hBEEF;
    miscompares = 0;
    n_checks = 0;
    cyc = 0;
    run = 0;
    halt_len = 0;
    wv_n = 0;
    w1e = 16'h0000;
    w1f = 16'h0000;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    // Every register, and one unmapped index, reads zero after reset.
    for (i = 0; i < 14; i++) rchk(i[3:0], 8'h00, "reset value");
    $display("test reset done");
    // Address high keeps six bits; the top two read as zero.
    wr(REG_ADDRH, 8'hFF);
    rchk(REG_ADDRH, 8'h3F, "addr high");
    wr(REG_ADDRL, 8'h3E);
    rchk(REG_ADDRL, 8'h3E, "addr low");
    // Software cannot set the unlock status, and a locked buffer ignores loads.
    wr(REG_OPCTL, 8'h80);
    rchk(REG_OPCTL, 8'h00, "status by software");
    wr(REG_D0L + 4'h1, 8'hAA);
    rchk(REG_ADDRL, 8'h3E, "locked load");
    $display("test locked done");
    // The reset pattern gives one pulse; any other value gives none.
    wr(REG_CHIPRST, CHIP_RST_KEY);
    chk("reset pulse", 16'h0001, {15'h0, chip_reset});
    @(posedge clock);
    #1;
    chk("reset pulse end", 16'h0000, {15'h0, chip_reset});
    wr(REG_CHIPRST, 8'h54);
    chk("no reset pulse", 16'h0000, {15'h0, chip_reset});
    rchk(REG_CHIPRST, 8'h54, "pattern reg");
    $display("test chip reset done");
    // Unlock: mode 110 plus trigger, then the six-byte pattern in documented order.
    wr(REG_OPCTL, {1'b0, MODE_UNLOCK, 4'h8});
    for (i = 0; i < 3; i++) wr(REG_D0L + 4'(2 * i + 2), UNLOCK_KEY[8 * i +: 8]);
    for (i = 0; i < 3; i++) wr(REG_D0L + 4'(2 * i + 3), UNLOCK_KEY[24 + 8 * i +: 8]);
    rchk(REG_OPCTL, 8'h68, "unlock timer running");
    for (i = 0; i < 1200 && rdv[B_UNLOCK_TRIG] !== 1'b0; i++) rd(REG_OPCTL);
    chk("unlock timer length", 16'h0001, {15'h0, i > 900 && i < 1200});
    rchk(REG_OPCTL, 8'hE0, "unlocked");
    $display("test unlock done");
    // Buffer clear bit drops by itself.
    wr(REG_TIMBUF, 8'h01);
    rchk(REG_TIMBUF, 8'h01, "clear busy");
    for (i = 0; i < 40 && rdv[B_BUF_CLR] !== 1'b0; i++) rd(REG_TIMBUF);
    rchk(REG_TIMBUF, 8'h00, "clear done");
    // Word loads increment the address and stop at the page's last word.
    wr(REG_D0L, 8'h34);
    wr(REG_D0L + 4'h1, 8'h12);
    rchk(REG_ADDRL, 8'h3F, "addr step");
    wr(REG_D0L, 8'h78);
    wr(REG_D0L + 4'h1, 8'h56);
    rchk(REG_ADDRL, 8'h3F, "addr page end");
    rchk(REG_ADDRH, 8'h3F, "addr high held");
    $display("test load done");
    // Reserved and unsuited modes refuse the write trigger.
    for (i = 2; i < 8; i++) begin
      wr(REG_OPCTL, 8'h84 | 8'(i << 4));
      rchk(REG_OPCTL, 8'h80 | 8'(i << 4), "mode refuse");
    end
    chk("no stall", 16'h0000, {15'h0, cpu_halt});
    // Write with short timing: busy flag, stall length, streamed words, frozen address.
    wv_n = 0;
    wr(REG_OPCTL, 8'h84);
    chk("write stall", 16'h0001, {15'h0, cpu_halt});
    chk("write level", 16'h0001, {15'h0, flash_cmd.write});
    chk("array address", 16'h3F3F, {2'h0, flash_cmd.addr});
    chk("page tags", 16'hC000, flash_cmd.tag[31:16]);
    wr(REG_ADDRL, 8'h00);
    rchk(REG_OPCTL, 8'h84, "write busy");
    wait_idle();
    chk("write length", 16'h0001, {15'h0, halt_len >= W0 - 1 && halt_len <= W0 + 1});
    chk("streamed words", 16'd32, 16'(wv_n));
    chk("word 1E", 16'h1234, w1e);
    chk("word 1F", 16'h5678, w1f);
    rchk(REG_OPCTL, 8'h80, "write done");
    rchk(REG_ADDRL, 8'h3F, "addr frozen");
    // A second write, with the long timing, streams an emptied buffer.
    wr(REG_TIMBUF, 8'h02);
    wr(REG_OPCTL, 8'h84);
    wait_idle();
    chk("write2 length", 16'h0001, {15'h0, halt_len >= W1 - 1 && halt_len <= W1 + 1});
    chk("buffer emptied", 16'h0000, w1e);
    $display("test write done");
    // Erase with the long timing selection.
    wr(REG_TIMBUF, 8'h02);
    wr(REG_OPCTL, 8'h94);
    chk("erase level", 16'h0001, {15'h0, flash_cmd.erase});
    wait_idle();
    chk("erase length", 16'h0001, {15'h0, halt_len >= E1 - 1 && halt_len <= E1 + 1});
    rchk(REG_OPCTL, 8'h90, "erase done");
    $display("test erase done");
    // Read refused without the enable, then a one-word read.
    wr(REG_OPCTL, 8'hB1);
    chk("read refused", 16'h0000, {15'h0, cpu_halt});
    rchk(REG_OPCTL, 8'hB0, "read bit clear");
    wr(REG_OPCTL, 8'hB3);
    chk("read stall", 16'h0001, {15'h0, cpu_halt});
    chk("read level", 16'h0001, {15'h0, flash_cmd.read});
    wait_idle();
    chk("read length", 16'h0001, {15'h0, halt_len >= 9 && halt_len <= 11});
    rchk(REG_OPCTL, 8'hB2, "read done");
    rchk(REG_D0L, 8'hEF, "read low");
    rchk(REG_D0L + 4'h1, 8'hBE, "read high");
    $display("test read done");
    // Clearing the status locks erase and write again.
    wr(REG_OPCTL, 8'h00);
    rchk(REG_OPCTL, 8'h00, "relock");
    wr(REG_OPCTL, 8'h04);
    rchk(REG_OPCTL, 8'h00, "locked write refused");
    chk("locked no stall", 16'h0000, {15'h0, cpu_halt});
    $display("test relock done");
    wrap_up();
  end
endmodule // fspc_ctrl_tb
